/* File: core/ldc_config_decode.sv */
// Configuration register bank and setting decoder of an LED driver.
`timescale 1ns/1ns
// Overview of operation
// - Two 2-bit step fields map 00..11 to 105, 210, 420, 840 mV.
// - Fault field maps 00..11 to a 5, 4, 3, 2 V high threshold.
// - Hysteresis field adds 1000, 750, 500, 250 mV to driver headroom.
// - Both frequency strap selects low: rates come from stored codes.
// - Stored switch code 00 gives 312 kHz, 01 gives 625 kHz.
// - Stored 4-bit dim code picks one of sixteen PWM rates.
// - Current strap select low: current from stored code and value.
// - Full-scale code maps to 5..50 mA, scaled by value over 4095.
// - Both strap selects high: rates from resistor; open gives 1250/9616.
// - Resistor band picks 312/625/1250 kHz and a 2402..19232 Hz rate.
// - Strap pin grounded: 1250 kHz, dimming follows PWM input.
// - Current strap select high: resistor sets full scale, codes scale.
// - Resistor current is value/4095 times max times 24k over resistor.
module ldc_config_decode #(
	parameter int         BAND_W    = 5,
	parameter logic [7:0] HSF_RESET = ldc_pkg::LDC_HSF_RESET,
	parameter logic [7:0] REV_RESET = ldc_pkg::LDC_REV_RESET
) (
	input  wire logic              clock,                    // Clock.
	input  wire logic              srst,                     // Reset.
	input  wire logic [7:0]        reg_addr,                 // Address.
	input  wire logic              reg_wr,                   // Write strobe.
	input  wire logic [7:0]        reg_wdata,                // Write data.
	input  wire logic              reg_rd,                   // Read strobe.
	output logic [7:0]             reg_rdata,                // Read data.
	input  wire logic              switch_freq_strap_select, // Sw from pin.
	input  wire logic              dim_freq_strap_select,    // Dim from pin.
	input  wire logic              current_strap_select,     // I from pin.
	input  wire logic [1:0]        switch_freq_code,         // Stored code.
	input  wire logic [3:0]        dim_freq_code,            // Stored code.
	input  wire logic [2:0]        full_scale_level,         // Max code.
	input  wire logic [11:0]       current_value,            // Scale value.
	input  wire logic [BAND_W-1:0] frequency_strap_band,     // Strap band.
	output logic [12:0]            step_up_mv,               // Up step.
	output logic [12:0]            headroom_lower_step_mv,   // Down step.
	output logic [12:0]            headroom_fault_level_mv,  // High level.
	output logic [12:0]            mid_comparator_offset_mv, // Mid offset.
	output ldc_pkg::ldc_freq_t     freq_setting,             // Rates.
	output logic [17:0]            led_current_num,          // mA*value.
	output logic                   current_strap_active      // I by pin.
);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	generate
		if (BAND_W < 5)
		begin : g_bad_band
			$error("BAND_W must be at least 5");
		end
	endgenerate

	logic [7:0]         hsf_r;
	logic [7:0]         rev_r;
	ldc_pkg::ldc_freq_t strap_freq;
	logic [4:0]         band;

	// Codes beyond the band field read as an open strap.
	assign band = (frequency_strap_band > BAND_W'(ldc_pkg::LDC_BAND_GND))
		? ldc_pkg::LDC_BAND_OPEN : frequency_strap_band[4:0];

	ldc_strap_decode u_strap (
		.band (band),
		.freq (strap_freq)
	);

	// ----------------------------------------------------------------
	// Register bank
	// ----------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (srst)
			hsf_r <= HSF_RESET;
		else if (reg_wr && reg_addr == ldc_pkg::LDC_ADDR_HSF)
			hsf_r <= reg_wdata;
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			rev_r <= REV_RESET;
		else if (reg_wr && reg_addr == ldc_pkg::LDC_ADDR_REV)
			rev_r <= reg_wdata;
	end

	// Unmapped addresses read as zero.
	always_ff @(posedge clock)
	begin
		if (srst)
			reg_rdata <= '0;
		else if (reg_rd)
		begin
			if (reg_addr == ldc_pkg::LDC_ADDR_HSF)
				reg_rdata <= hsf_r;
			else if (reg_addr == ldc_pkg::LDC_ADDR_REV)
				reg_rdata <= rev_r;
			else
				reg_rdata <= '0;
		end
	end

	// ----------------------------------------------------------------
	// Headroom decode
	// ----------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			step_up_mv <= '0;
			headroom_lower_step_mv <= '0;
			headroom_fault_level_mv <= '0;
			mid_comparator_offset_mv <= '0;
		end
		else
		begin
			step_up_mv <= ldc_pkg::LDC_STEP_MV[
				hsf_r[ldc_pkg::LDC_STEP_UP_LSB +: 2]];
			headroom_lower_step_mv <= ldc_pkg::LDC_STEP_MV[
				hsf_r[ldc_pkg::LDC_HEADROOM_LOWER_STEP_LSB +: 2]];
			headroom_fault_level_mv <= ldc_pkg::LDC_FAULT_MV[
				hsf_r[ldc_pkg::LDC_FAULT_LSB +: 2]];
			mid_comparator_offset_mv <= ldc_pkg::LDC_HYST_MV[
				hsf_r[ldc_pkg::LDC_HYST_LSB +: 2]];
		end
	end

	// ----------------------------------------------------------------
	// Frequency selection
	// ----------------------------------------------------------------
	// Each select steers its own rate; mixed settings are served per rate.
	always_ff @(posedge clock)
	begin
		if (srst)
			freq_setting <= '0;
		else
		begin
			if (switch_freq_strap_select)
				freq_setting.sw_khz <= strap_freq.sw_khz;
			else
				freq_setting.sw_khz <=
					ldc_pkg::LDC_SW_KHZ[switch_freq_code];
			if (dim_freq_strap_select)
			begin
				freq_setting.pwm_hz <= strap_freq.pwm_hz;
				freq_setting.pwm_bits <= strap_freq.pwm_bits;
				freq_setting.pwm_follow <= strap_freq.pwm_follow;
			end
			else
			begin
				freq_setting.pwm_hz <=
					ldc_pkg::LDC_DIM_HZ[dim_freq_code];
				freq_setting.pwm_bits <= ldc_pkg::LDC_DIM_BITS[dim_freq_code];
				freq_setting.pwm_follow <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Current selection
	// ----------------------------------------------------------------
	// The product is full scale times value; the sink divides by 4095 and,
	// in strap mode, applies the resistor ratio in the analog domain.
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			led_current_num <= '0;
			current_strap_active <= 1'b0;
		end
		else
		begin
			led_current_num <=
				{12'h000, ldc_pkg::LDC_IMAX_MA[full_scale_level]}
				* {6'h00, current_value};
			current_strap_active <= current_strap_select;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	a_step_map: assert property (
		$past(reg_wr) && $past(reg_addr) == ldc_pkg::LDC_ADDR_HSF &&
		!$past(srst) |=> step_up_mv ==
		ldc_pkg::LDC_STEP_MV[$past(reg_wdata[7:6], 2)]
		&& headroom_lower_step_mv == ldc_pkg::LDC_STEP_MV[
		$past(reg_wdata[5:4], 2)])
		else $error("step size does not follow written code");

	a_fault_level: assert property (
		!$past(srst) |-> headroom_fault_level_mv ==
		ldc_pkg::LDC_FAULT_MV[$past(hsf_r[3:2])])
		else $error("fault level does not follow code");

	a_mid_offset: assert property (
		!$past(srst) |-> mid_comparator_offset_mv ==
		ldc_pkg::LDC_HYST_MV[$past(hsf_r[1:0])])
		else $error("mid offset does not follow code");

	a_stored_switch: assert property (
		!switch_freq_strap_select && switch_freq_code == 2'h1 |=>
		freq_setting.sw_khz == ldc_pkg::LDC_SW_625)
		else $error("stored switch code 01 not 625 kHz");

	a_stored_dim: assert property (
		!dim_freq_strap_select |=> freq_setting.pwm_hz ==
		ldc_pkg::LDC_DIM_HZ[$past(dim_freq_code)] && !freq_setting.pwm_follow)
		else $error("stored dim code not decoded");

	a_stored_current: assert property (
		full_scale_level == 3'h7 && current_value == 12'hfff |=>
		led_current_num == 18'h31fce)
		else $error("50 mA full scale product wrong");

	a_strap_open: assert property (
		switch_freq_strap_select && dim_freq_strap_select &&
		band == ldc_pkg::LDC_BAND_OPEN |=>
		freq_setting.sw_khz == ldc_pkg::LDC_SW_1250 &&
		freq_setting.pwm_hz == ldc_pkg::LDC_OPEN_HZ)
		else $error("open strap not 1250 kHz and 9616 Hz");

	a_strap_band: assert property (
		switch_freq_strap_select && band == ldc_pkg::LDC_BAND_SW1 |=>
		freq_setting.sw_khz == ldc_pkg::LDC_SW_625)
		else $error("first 625 kHz band wrong");

	a_strap_ground: assert property (
		dim_freq_strap_select && switch_freq_strap_select &&
		band == ldc_pkg::LDC_BAND_GND |=> freq_setting.pwm_follow &&
		freq_setting.sw_khz == ldc_pkg::LDC_SW_1250)
		else $error("grounded strap not following PWM input");

	a_current_mode: assert property (
		current_strap_select |=> current_strap_active ##1
		current_strap_active == $past(current_strap_select))
		else $error("current strap mode not reported");

endmodule // ldc_config_decode

/* File: core/ldc_pkg.sv */
// Package of constants, tables and types for the LED driver config decoder.
package ldc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] LDC_ADDR_HSF = 8'hae;
	localparam logic [7:0] LDC_ADDR_REV = 8'haf;
	localparam logic [7:0] LDC_HSF_RESET = 8'h00;
	localparam logic [7:0] LDC_REV_RESET = 8'h00;
	localparam int LDC_STEP_UP_LSB = 6;
	localparam int LDC_HEADROOM_LOWER_STEP_LSB = 4;
	localparam int LDC_FAULT_LSB = 2;
	localparam int LDC_HYST_LSB = 0;

	// ----------------------------------------------------------------
	// Decode tables
	// ----------------------------------------------------------------
	localparam logic [12:0] LDC_STEP_MV [4] = '{13'h0069, 13'h00d2,
		13'h01a4, 13'h0348};
	localparam logic [12:0] LDC_FAULT_MV [4] = '{13'h1388, 13'h0fa0,
		13'h0bb8, 13'h07d0};
	localparam logic [12:0] LDC_HYST_MV [4] = '{13'h03e8, 13'h02ee,
		13'h01f4, 13'h00fa};
	localparam logic [10:0] LDC_SW_312 = 11'h138;
	localparam logic [10:0] LDC_SW_625 = 11'h271;
	localparam logic [10:0] LDC_SW_1250 = 11'h4e2;
	// Code 3 is reserved and is served like code 2.
	localparam logic [10:0] LDC_SW_KHZ [4] = '{LDC_SW_312, LDC_SW_625,
		LDC_SW_1250, LDC_SW_1250};
	localparam logic [15:0] LDC_DIM_HZ [16] = '{16'h12c8, 16'h177a,
		16'h1c2c, 16'h20de, 16'h2590, 16'h2ef4, 16'h33a6, 16'h3858,
		16'h3d0a, 16'h41bc, 16'h466e, 16'h4b20, 16'h5de8, 16'h70b0,
		16'h8378, 16'h9640};
	localparam logic [3:0] LDC_DIM_BITS [16] = '{4'hb, 4'ha, 4'ha, 4'ha,
		4'ha, 4'h9, 4'h9, 4'h9, 4'h9, 4'h9, 4'h9, 4'h9, 4'h8, 4'h8,
		4'h8, 4'h8};
	localparam logic [5:0] LDC_IMAX_MA [8] = '{6'h05, 6'h0a, 6'h0f,
		6'h14, 6'h17, 6'h19, 6'h1e, 6'h32};

	// ----------------------------------------------------------------
	// Strap resistor bands
	// ----------------------------------------------------------------
	localparam logic [4:0] LDC_BAND_OPEN = 5'h00;
	localparam logic [4:0] LDC_BAND_FIRST = 5'h01;
	localparam logic [4:0] LDC_BAND_LAST = 5'h18;
	localparam logic [4:0] LDC_BAND_GND = 5'h19;
	localparam logic [4:0] LDC_BAND_SW1 = 5'h09;
	localparam logic [4:0] LDC_BAND_SW2 = 5'h11;
	localparam logic [15:0] LDC_OPEN_HZ = 16'h2590;
	localparam logic [3:0] LDC_OPEN_BITS = 4'ha;
	localparam logic [15:0] LDC_BAND_HZ [8] = '{16'h0962, 16'h12c8,
		16'h177a, 16'h2590, 16'h2ef4, 16'h3858, 16'h41bc, 16'h4b20};
	localparam logic [3:0] LDC_BAND_BITS [8] = '{4'hc, 4'hb, 4'ha, 4'ha,
		4'h9, 4'h9, 4'h9, 4'h9};

	typedef struct packed {
		logic [10:0] sw_khz;
		logic [15:0] pwm_hz;
		logic [3:0]  pwm_bits;
		logic        pwm_follow;
	} ldc_freq_t;

endpackage

/* File: core/ldc_strap_decode.sv */
// Decoder from a measured frequency strap band to boost and dimming rates.
`timescale 1ns/1ns
module ldc_strap_decode (
	input  wire logic [4:0]       band,  // Measured strap resistor band.
	output ldc_pkg::ldc_freq_t    freq   // Rates the band selects.
);

	logic [4:0] idx;
	logic [2:0] sub;

	always_comb
	begin
		idx = band - ldc_pkg::LDC_BAND_FIRST;
		sub = idx[2:0];
		freq.pwm_follow = 1'b0;
		freq.sw_khz = ldc_pkg::LDC_SW_1250;
		freq.pwm_hz = ldc_pkg::LDC_OPEN_HZ;
		freq.pwm_bits = ldc_pkg::LDC_OPEN_BITS;
		if (band == ldc_pkg::LDC_BAND_GND)
		begin
			freq.pwm_follow = 1'b1;
			freq.pwm_hz = '0;
			freq.pwm_bits = '0;
		end
		else if (band >= ldc_pkg::LDC_BAND_FIRST &&
			band <= ldc_pkg::LDC_BAND_LAST)
		begin
			// Eight dimming bands repeat under each switching rate.
			freq.pwm_hz = ldc_pkg::LDC_BAND_HZ[sub];
			freq.pwm_bits = ldc_pkg::LDC_BAND_BITS[sub];
			if (band < ldc_pkg::LDC_BAND_SW1)
				freq.sw_khz = ldc_pkg::LDC_SW_312;
			else if (band < ldc_pkg::LDC_BAND_SW2)
				freq.sw_khz = ldc_pkg::LDC_SW_625;
		end
	end

endmodule // ldc_strap_decode

/* File: verif/ldc_config_decode_tb.sv */
// Self-checking testbench of the LED driver configuration decoder.
`timescale 1ns/1ns
module ldc_config_decode_tb;
	logic               clock;
	logic               srst;
	logic [7:0]         reg_addr;
	logic               reg_wr;
	logic [7:0]         reg_wdata;
	logic               reg_rd;
	logic [7:0]         reg_rdata;
	logic               sw_sel;
	logic               dim_sel;
	logic               cur_sel;
	logic [1:0]         sw_code;
	logic [3:0]         dim_code;
	logic [2:0]         fs_code;
	logic [11:0]        cur_val;
	logic [4:0]         band;
	logic [12:0]        up_mv;
	logic [12:0]        dn_mv;
	logic [12:0]        fault_mv;
	logic [12:0]        mid_mv;
	ldc_pkg::ldc_freq_t freq;
	logic [17:0]        cur_num;
	logic               cur_act;
	int                 failures;
	int                 total_checks;
	int                 cycles;
	int step_tab[4] = '{105, 210, 420, 840};
	int fault_tab[4] = '{5000, 4000, 3000, 2000};
	int hyst_tab[4] = '{1000, 750, 500, 250};
	int sw_tab[3] = '{312, 625, 1250};
	int dim_hz[16] = '{4808, 6010, 7212, 8414, 9616, 12020, 13222, 14424,
		15626, 16828, 18030, 19232, 24040, 28848, 33656, 38464};
	int dim_b[16] = '{11, 10, 10, 10, 10, 9, 9, 9, 9, 9, 9, 9, 8, 8, 8, 8};
	int ma_tab[8] = '{5, 10, 15, 20, 23, 25, 30, 50};
	int bd[9] = '{0, 1, 8, 9, 16, 17, 24, 25, 31};
	int bd_sw[9] = '{1250, 312, 312, 625, 625, 1250, 1250, 1250, 1250};
	int bd_hz[9] = '{9616, 2402, 19232, 2402, 19232, 2402, 19232, 0, 9616};
	int bd_b[9] = '{10, 12, 9, 12, 9, 12, 9, 0, 10};

	ldc_config_decode u_ldc_config_decode (
		.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.switch_freq_strap_select(sw_sel), .dim_freq_strap_select(dim_sel),
		.current_strap_select(cur_sel), .switch_freq_code(sw_code),
		.dim_freq_code(dim_code), .full_scale_level(fs_code),
		.current_value(cur_val), .frequency_strap_band(band),
		.step_up_mv(up_mv), .headroom_lower_step_mv(dn_mv),
		.headroom_fault_level_mv(fault_mv),
		.mid_comparator_offset_mv(mid_mv), .freq_setting(freq),
		.led_current_num(cur_num), .current_strap_active(cur_act)
	);

	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic summarize();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			failures++;
			summarize();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic step();
		@(posedge clock);
		@(negedge clock);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		step();
		reg_wr = 1'b0;
		step();
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr = a;
		reg_rd = 1'b1;
		step();
		reg_rd = 1'b0;
		step();
		chk("reg_rdata", 32'(e), 32'(reg_rdata));
	endtask

	// Mid-run reset clears the outputs and both registers.
	task automatic t_reset();
		srst = 1'b1;
		step();
		srst = 1'b0;
		chk("step_up_mv", 0, 32'(up_mv));
		chk("fault_mv", 0, 32'(fault_mv));
		chk("freq_setting", 0, 32'(freq));
		chk("current_num", 0, 32'(cur_num));
		chk("current_strap_active", 0, 32'(cur_act));
		rd(8'hae, 8'h00);
		rd(8'haf, 8'h00);
	endtask

	// Reset values, read-back, and an unmapped address.
	task automatic t_regs();
		rd(8'hae, 8'h00);
		rd(8'haf, 8'h00);
		wr(8'haf, 8'ha5);
		rd(8'haf, 8'ha5);
		wr(8'h10, 8'h3c);
		rd(8'h10, 8'h00);
		rd(8'haf, 8'ha5);
	endtask

	// Each field decoded in its own bit position.
	task automatic t_fields();
		for (int c = 0; c < 4; c++)
		begin
			wr(8'hae, 8'((c << 6) | (c << 4) | (c << 2) | c));
			chk("step_up_mv", step_tab[c], 32'(up_mv));
			chk("lower_step_mv", step_tab[c], 32'(dn_mv));
			chk("fault_mv", fault_tab[c], 32'(fault_mv));
			chk("mid_offset_mv", hyst_tab[c], 32'(mid_mv));
		end
		wr(8'hae, 8'h1b);
		chk("step_up_mv", step_tab[0], 32'(up_mv));
		chk("lower_step_mv", step_tab[1], 32'(dn_mv));
		chk("fault_mv", fault_tab[2], 32'(fault_mv));
		chk("mid_offset_mv", hyst_tab[3], 32'(mid_mv));
		rd(8'hae, 8'h1b);
	endtask

	// Stored codes with both strap selects low.
	task automatic t_stored();
		sw_sel = 1'b0;
		dim_sel = 1'b0;
		for (int d = 0; d < 16; d++)
		begin
			sw_code = 2'(d % 3);
			dim_code = 4'(d);
			step();
			chk("freq_setting", {11'(sw_tab[d % 3]), 16'(dim_hz[d]),
				4'(dim_b[d]), 1'b0}, freq);
		end
	endtask

	// Strap band decode with both strap selects high.
	task automatic t_strap();
		sw_sel = 1'b1;
		dim_sel = 1'b1;
		for (int i = 0; i < 9; i++)
		begin
			band = 5'(bd[i]);
			step();
			chk("strap_freq", {11'(bd_sw[i]), 16'(bd_hz[i]), 4'(bd_b[i]),
				1'(i == 7)}, freq);
		end
	endtask

	// All full-scale current codes in stored current mode, then code 7 in strap current mode.
	task automatic t_current();
		cur_sel = 1'b0;
		cur_val = 12'hfff;
		for (int m = 0; m < 8; m++)
		begin
			fs_code = 3'(m);
			step();
			chk("current_num", ma_tab[m] * 4095, 32'(cur_num));
			chk("current_strap_active", 0, 32'(cur_act));
		end
		cur_val = 12'h001;
		cur_sel = 1'b1;
		step();
		chk("current_num", 50, 32'(cur_num));
		chk("current_strap_active", 1, 32'(cur_act));
	endtask

	initial
	begin
		srst = 1'b1;
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
		{sw_sel, dim_sel, cur_sel} = 3'h0;
		sw_code = 2'h0;
		dim_code = 4'h0;
		fs_code = 3'h0;
		cur_val = 12'h000;
		band = 5'h00;
		repeat (16) @(posedge clock);
		@(negedge clock);
		srst = 1'b0;
		t_regs();
		t_fields();
		t_stored();
		t_strap();
		t_current();
		t_reset();
		summarize();
	end
endmodule // ldc_config_decode_tb
